// file: verilog/pss_defines.svh
/*
  Constants of the pipelined synchronous SRAM core: widths, depth, lane layout, pipeline depth.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// ***********************************
// array geometry
// ***********************************
`define PSS_ADDR_W 18
`define PSS_DEPTH 262144
`define PSS_LANES 4
`define PSS_LANE_W 9
`define PSS_DATA_W 36

// ***********************************
// burst and pipeline
// ***********************************
`define PSS_CNT_W 2
`define PSS_CNT_RST 2'h0
`define PSS_DATA_LAT 2

`endif

// file: verilog/pss_pkg.sv
/*
  Types of the pipelined synchronous SRAM core: pipeline slots, burst control, full state.
  Assumes pss_defines.svh is on the include path.
*/
`include "pss_defines.svh"

package pss_pkg;

  // ***********************************
  // burst state
  // ***********************************
  typedef enum logic [1:0] {burst_idle, burst_read, burst_write} pss_burst_t;

  // one accepted command moving down the pipe; lanes are active high
  typedef struct packed {
    logic valid;
    logic write;
    logic [`PSS_ADDR_W-1:0] addr;
    logic [`PSS_LANES-1:0] lanes;
  } pss_slot_t;

  // a write whose data has been caught and waits for the array
  typedef struct packed {
    logic valid;
    logic [`PSS_ADDR_W-1:0] addr;
    logic [`PSS_LANES-1:0] lanes;
    logic [`PSS_DATA_W-1:0] data;
  } pss_commit_t;

  typedef struct packed {
    pss_burst_t mode;
    logic [`PSS_ADDR_W-1:0] base;
    logic [`PSS_CNT_W-1:0] start;
    logic [`PSS_CNT_W-1:0] count;
  } pss_burst_ctl_t;

  typedef struct packed {
    pss_slot_t s1;
    pss_slot_t s2;
    pss_commit_t s3;
    pss_burst_ctl_t burst;
    logic [`PSS_DATA_W-1:0] dout;
    logic drive;
    logic [1:0] mode_sync;
    logic [1:0] sleep_sync;
    logic power_down;
  } pss_state_t;

endpackage

// file: verilog/pss_array.sv
/*
  Storage array of the SRAM core: flip-flop words with per-lane write and combinational read.
  Assumes the caller orders writes and forwards data still in flight.
*/
`timescale 1ns/10ps
`include "pss_defines.svh"

module pss_array (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [`PSS_ADDR_W-1:0] wr_addr,
  input wire logic [`PSS_LANES-1:0] wr_lanes,
  input wire logic [`PSS_DATA_W-1:0] wr_data,
  input wire logic [`PSS_ADDR_W-1:0] rd_addr,
  output logic [`PSS_DATA_W-1:0] rd_data
);

  logic [`PSS_DATA_W-1:0] cells [0:`PSS_DEPTH-1];

  // ***********************************
  // write, one enable per nine-bit lane
  // ***********************************
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < `PSS_LANES; i++) begin
      if (wr_en && wr_lanes[i]) begin
        cells[wr_addr][i*`PSS_LANE_W +: `PSS_LANE_W] <= wr_data[i*`PSS_LANE_W +: `PSS_LANE_W];
      end
    end
  end

  assign rd_data = cells[rd_addr];

endmodule

// file: verilog/pss_core.sv
/*
  Pipelined synchronous SRAM core with four-word bursts and no turnaround between reads and writes.
  Assumes the host runs on core_clk and drives write data two cycles after the write command;
  out_enable_n, sleep_request and burst_interleave may change at any time.
*/
// Functional notes
// - all synchronous inputs are caught in registers on the rising clock edge
// - read data appears and write data is taken two cycles after the command
// - reads and writes may follow each other on consecutive cycles, no idle cycle
// - clock hold high freezes all but the sync and power-down registers and ignores synchronous inputs
// - deselect with load starts no access and stops any running burst
// - transfers already in the pipe still complete after a deselect
// - data bus goes high impedance two cycles after a deselect or a write
// - a two-bit burst counter yields four words from one address
// - the burst order input picks linear or interleaved sequence
// - load low takes a new address; load high advances the burst counter
// - output enable turns the data drivers off at any time, without clock
// - one read/write select; byte lanes may be tied low for whole words
// - three chip selects; power-down by sleep or by deselection
// - select 2 active high, selects 1 and 3 active low, all must agree
// - byte lanes ignored on reads; writes store enabled lanes two cycles later
// - burst counter starts from the two low address bits
`timescale 1ns/10ps
`include "pss_defines.svh"

module pss_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [`PSS_ADDR_W-1:0] address,
  input wire logic advance_or_load,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic clock_hold_n,
  input wire logic read_write_n,
  input wire logic [`PSS_LANES-1:0] byte_write_lanes_n,
  input wire logic [`PSS_DATA_W-1:0] data_byte_lanes_in,
  output logic [`PSS_DATA_W-1:0] data_byte_lanes_out,
  output logic [`PSS_LANES-1:0] data_byte_lanes_oe,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic burst_interleave,
  output logic power_down
);

  pss_pkg::pss_state_t st;
  pss_pkg::pss_state_t next_st;
  pss_pkg::pss_slot_t slot;
  logic [`PSS_DATA_W-1:0] rd_data;
  logic [`PSS_DATA_W-1:0] merged;
  logic [`PSS_CNT_W-1:0] next_cnt;
  logic hold_ok;
  logic selected;
  logic asleep;
  logic interleave;
  logic load_ok;
  logic wr_en;

  // ***********************************
  // helpers
  // ***********************************
  // low address bits of a burst beat
  function automatic logic [`PSS_CNT_W-1:0] burst_low(input logic [`PSS_CNT_W-1:0] start,
                                                      input logic [`PSS_CNT_W-1:0] cnt,
                                                      input logic il);
    logic [`PSS_CNT_W-1:0] r;
    r = il ? (start ^ cnt) : `PSS_CNT_W'(start + cnt);
    return r;
  endfunction

  // overlay the enabled lanes of a newer write onto a word
  function automatic logic [`PSS_DATA_W-1:0] lane_merge(input logic [`PSS_DATA_W-1:0] word,
                                                        input logic [`PSS_LANES-1:0] lanes,
                                                        input logic [`PSS_DATA_W-1:0] data);
    logic [`PSS_DATA_W-1:0] r;
    r = word;
    for (int i = 0; i < `PSS_LANES; i++) begin
      if (lanes[i]) begin
        r[i*`PSS_LANE_W +: `PSS_LANE_W] = data[i*`PSS_LANE_W +: `PSS_LANE_W];
      end
    end
    return r;
  endfunction

  // ***********************************
  // array
  // ***********************************
  assign wr_en = st.s3.valid && hold_ok;

  pss_array u_array (
    .core_clk(core_clk),
    .wr_en(wr_en),
    .wr_addr(st.s3.addr),
    .wr_lanes(st.s3.lanes),
    .wr_data(st.s3.data),
    .rd_addr(st.s1.addr),
    .rd_data(rd_data)
  );

  // ***********************************
  // decode
  // ***********************************
  assign hold_ok = !clock_hold_n;
  assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign asleep = st.sleep_sync[1];
  assign interleave = st.mode_sync[1];
  assign load_ok = !advance_or_load && selected && !asleep;

  // forward writes not yet in the array so a read right behind a write sees it
  always_comb begin
    merged = rd_data;
    if (st.s3.valid && st.s3.addr == st.s1.addr) begin
      merged = lane_merge(merged, st.s3.lanes, st.s3.data);
    end
    if (st.s2.valid && st.s2.write && st.s2.addr == st.s1.addr) begin
      merged = lane_merge(merged, st.s2.lanes, data_byte_lanes_in);
    end
  end

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    next_st = st;
    slot = '0;
    next_cnt = `PSS_CNT_W'(st.burst.count + 2'h1);
    next_st.mode_sync = {st.mode_sync[0], burst_interleave};
    next_st.sleep_sync = {st.sleep_sync[0], sleep_request};
    if (hold_ok) begin
      if (!advance_or_load) begin
        if (load_ok) begin
          next_st.burst.mode = read_write_n ? pss_pkg::burst_read : pss_pkg::burst_write;
          next_st.burst.base = address;
          next_st.burst.start = address[`PSS_CNT_W-1:0];
          next_st.burst.count = `PSS_CNT_RST;
          slot.valid = 1'b1;
          slot.write = !read_write_n;
          slot.addr = address;
        end else begin
          next_st.burst.mode = pss_pkg::burst_idle;
        end
      end else begin
        case (st.burst.mode)
          pss_pkg::burst_read, pss_pkg::burst_write: begin
            if (asleep) begin
              next_st.burst.mode = pss_pkg::burst_idle;
            end else begin
              next_st.burst.count = next_cnt;
              slot.valid = 1'b1;
              slot.write = (st.burst.mode == pss_pkg::burst_write);
              slot.addr = {st.burst.base[`PSS_ADDR_W-1:`PSS_CNT_W],
                           burst_low(st.burst.start, next_cnt, interleave)};
            end
          end
          default: begin
            next_st.burst.mode = pss_pkg::burst_idle;
          end
        endcase
      end
      slot.lanes = slot.write ? ~byte_write_lanes_n : '0;
      next_st.s1 = slot;
      next_st.s2 = st.s1;
      next_st.s3.valid = st.s2.valid && st.s2.write;
      next_st.s3.addr = st.s2.addr;
      next_st.s3.lanes = st.s2.lanes;
      next_st.s3.data = data_byte_lanes_in;
      next_st.drive = st.s1.valid && !st.s1.write && !asleep;
      if (st.s1.valid && !st.s1.write) begin
        next_st.dout = merged;
      end
    end
    next_st.power_down = asleep || (st.burst.mode == pss_pkg::burst_idle && !st.s1.valid
                                    && !st.s2.valid && !st.s3.valid);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign data_byte_lanes_out = st.dout;
  // output enable acts without the clock, so it gates the registered drive directly
  assign data_byte_lanes_oe = {`PSS_LANES{st.drive && !out_enable_n}};
  assign power_down = st.power_down;

  // ***********************************
  // checks
  // ***********************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_read_latency: assert property (
    (load_ok && hold_ok && read_write_n) ##1 (hold_ok && !asleep) |=> st.drive
  ) else $error("read data not driven two cycles after read command");

  chk_write_tristate: assert property (
    (load_ok && hold_ok && !read_write_n) ##1 hold_ok |=> !st.drive
  ) else $error("bus driven two cycles after write command");

  chk_deselect_stop: assert property (
    (hold_ok && !advance_or_load && !load_ok) |=>
      (st.burst.mode == pss_pkg::burst_idle && !st.s1.valid)
  ) else $error("deselect did not stop the burst");

  chk_deselect_tristate: assert property (
    (hold_ok && !advance_or_load && !load_ok) ##1 hold_ok |=> !st.drive
  ) else $error("bus driven two cycles after deselect");

  chk_hold_freeze: assert property (
    clock_hold_n |=> ($stable(st.s1) && $stable(st.s2) && $stable(st.s3)
                      && $stable(st.burst) && $stable(st.dout) && $stable(st.drive))
  ) else $error("state changed while clock hold was high");

  chk_burst_seed: assert property (
    (load_ok && hold_ok) |=> (st.burst.count == `PSS_CNT_RST && st.s1.addr == $past(address))
  ) else $error("burst not seeded from the loaded address");

  chk_linear_step: assert property (
    (hold_ok && advance_or_load && st.burst.mode != pss_pkg::burst_idle && !asleep
     && !interleave) |=> st.s1.addr[1:0] == $past(st.burst.start + st.burst.count + 2'h1)
  ) else $error("linear burst address wrong");

  chk_interleave_step: assert property (
    (hold_ok && advance_or_load && st.burst.mode != pss_pkg::burst_idle && !asleep
     && interleave) |=> st.s1.addr[1:0] == $past(st.burst.start ^ (st.burst.count + 2'h1))
  ) else $error("interleaved burst address wrong");

  chk_write_capture: assert property (
    (hold_ok && st.s2.valid && st.s2.write) |=>
      (st.s3.valid && st.s3.data == $past(data_byte_lanes_in) && st.s3.lanes == $past(st.s2.lanes))
  ) else $error("write data not caught two cycles after command");

  chk_pipe_drain: assert property (
    (hold_ok && st.s1.valid) |=> (st.s2 == $past(st.s1))
  ) else $error("pending transfer lost from the pipe");

  chk_read_lanes: assert property (
    (load_ok && hold_ok && read_write_n) |=> st.s1.lanes == 4'h0
  ) else $error("byte lanes not ignored on a read");

  chk_sleep_quiet: assert property (
    (hold_ok && asleep) |=> (!st.drive && !st.s1.valid)
  ) else $error("access started or bus driven while asleep");

  chk_sleep_power: assert property (
    asleep |=> power_down
  ) else $error("power down not flagged while asleep");

  chk_awake_active: assert property (
    (load_ok && hold_ok) ##1 !asleep |=> !power_down
  ) else $error("power down flagged during an access");

  chk_load_direction: assert property (
    (load_ok && hold_ok) |=> st.s1.write == !$past(read_write_n)
  ) else $error("loaded direction differs from read/write select");

  chk_select_polarity: assert property (
    (hold_ok && !advance_or_load && !asleep && !chip_select_1_n && chip_select_2
     && !chip_select_3_n) |=> st.s1.valid
  ) else $error("selected load did not start an access");

  chk_advance_idle: assert property (
    (hold_ok && advance_or_load && st.burst.mode == pss_pkg::burst_idle) |=> !st.s1.valid
  ) else $error("advance without a burst started an access");

  chk_upper_fixed: assert property (
    (hold_ok && advance_or_load && st.burst.mode != pss_pkg::burst_idle && !asleep) |=>
      (st.s1.valid && st.s1.addr[`PSS_ADDR_W-1:`PSS_CNT_W]
       == $past(st.burst.base[`PSS_ADDR_W-1:`PSS_CNT_W]))
  ) else $error("burst left its loaded upper address");

  chk_burst_direction: assert property (
    (hold_ok && advance_or_load && st.burst.mode == pss_pkg::burst_write && !asleep) |=>
      (st.s1.write && st.s1.lanes == $past(~byte_write_lanes_n))
  ) else $error("write burst beat lost direction or lanes");

  chk_read_drive: assert property (
    (hold_ok && st.s1.valid && !st.s1.write && !asleep) |=> st.drive
  ) else $error("read beat not driven on the bus");

  cov_read_burst: cover property (
    (load_ok && hold_ok && read_write_n) ##1 (hold_ok && advance_or_load)[*3]
  );
  cov_write_then_read: cover property (
    (load_ok && hold_ok && !read_write_n) ##1 (load_ok && hold_ok && read_write_n)
  );
  cov_hold_mid_burst: cover property (
    (st.burst.mode != pss_pkg::burst_idle) ##1 clock_hold_n
  );
  cov_deselect: cover property (
    st.s1.valid ##1 (hold_ok && !advance_or_load && !load_ok)
  );
  cov_interleave_write: cover property (
    (hold_ok && advance_or_load && interleave && st.burst.mode == pss_pkg::burst_write)
  );

endmodule

// file: tb/pss_host_model.sv
/*
  Host-side data driver: puts each write word on the bus two counted edges after its command.
  Assumes the bench flags every write beat at the edge that issues it.
*/
`timescale 1ns/10ps
`include "pss_defines.svh"

module pss_host_model (
  input wire logic core_clk,
  input wire logic clock_hold_n,
  input wire logic wr_beat,
  input wire logic [`PSS_DATA_W-1:0] wr_word,
  output logic [`PSS_DATA_W-1:0] bus_data
);
  logic v1 = 1'b0;
  logic v2 = 1'b0;
  logic [`PSS_DATA_W-1:0] w1 = '0;
  logic [`PSS_DATA_W-1:0] w2 = '0;
  logic [`PSS_DATA_W-1:0] last = '0;

  // held edges do not advance the data pipe
  always @(posedge core_clk) begin
    if (clock_hold_n === 1'b0) begin
      v1 <= wr_beat;
      w1 <= wr_word;
      v2 <= v1;
      w2 <= w1;
      if (v1) begin
        last <= w1;
      end
    end
  end

  // released bus shows the inverse of the last word
  assign bus_data = v2 ? w2 : ~last;
endmodule

// file: tb/pss_core_tb.sv
/*
  Self-checking bench of the SRAM core: bursts, byte lanes, hold, deselect, output enable, sleep.
  Assumes pss_defines.svh on the include path and the host model beside it.
*/
`timescale 1ns/10ps
`include "pss_defines.svh"

module pss_core_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [`PSS_ADDR_W-1:0] address = '0;
  logic advance_or_load = 1'b0;
  logic chip_select_1_n = 1'b1;
  logic chip_select_2 = 1'b0;
  logic chip_select_3_n = 1'b1;
  logic clock_hold_n = 1'b0;
  logic read_write_n = 1'b1;
  logic [`PSS_LANES-1:0] byte_write_lanes_n = '0;
  logic [`PSS_DATA_W-1:0] bus_in;
  logic [`PSS_DATA_W-1:0] data_byte_lanes_out;
  logic [`PSS_LANES-1:0] data_byte_lanes_oe;
  logic out_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_interleave = 1'b0;
  logic power_down;
  logic wr_beat = 1'b0;
  logic [`PSS_DATA_W-1:0] wr_word = '0;
  logic counted = 1'b0;
  logic [15:0] rs = 16'h38d0;
  logic [`PSS_DATA_W-1:0] mem [logic [`PSS_ADDR_W-1:0]];
  logic [`PSS_DATA_W-1:0] exp_q [$];
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  pss_core uut (.core_clk(core_clk), .nrst(nrst), .address(address),
    .advance_or_load(advance_or_load), .chip_select_1_n(chip_select_1_n),
    .chip_select_2(chip_select_2), .chip_select_3_n(chip_select_3_n),
    .clock_hold_n(clock_hold_n), .read_write_n(read_write_n),
    .byte_write_lanes_n(byte_write_lanes_n), .data_byte_lanes_in(bus_in),
    .data_byte_lanes_out(data_byte_lanes_out), .data_byte_lanes_oe(data_byte_lanes_oe),
    .out_enable_n(out_enable_n), .sleep_request(sleep_request),
    .burst_interleave(burst_interleave), .power_down(power_down));

  pss_host_model host (.core_clk(core_clk), .clock_hold_n(clock_hold_n), .wr_beat(wr_beat),
    .wr_word(wr_word), .bus_data(bus_in));

  always #20 core_clk = ~core_clk;

  // ***********************************
  // helpers
  // ***********************************
  function automatic logic [`PSS_DATA_W-1:0] rword();
    logic [47:0] t = '0;
    for (int i = 0; i < 3; i++) begin
      rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
      t = {t[31:0], rs};
    end
    return t[`PSS_DATA_W-1:0];
  endfunction

  task automatic check(input logic [`PSS_DATA_W-1:0] e, input logic [`PSS_DATA_W-1:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one beat; sel picks a select to make false, 3 keeps all true
  task automatic beat(input logic adv, input logic wr, input logic [`PSS_ADDR_W-1:0] a,
                      input logic [3:0] ln, input logic push, input int sel);
    logic [`PSS_DATA_W-1:0] w;
    logic [`PSS_DATA_W-1:0] m;
    w = rword();
    @(posedge core_clk);
    advance_or_load <= adv;
    address <= adv ? w[`PSS_ADDR_W-1:0] : a;
    read_write_n <= adv ? w[20] : !wr;
    byte_write_lanes_n <= wr ? ln : w[25:22];
    chip_select_1_n <= sel == 0;
    chip_select_2 <= sel != 1;
    chip_select_3_n <= sel == 2;
    clock_hold_n <= 1'b0;
    wr_beat <= wr && push;
    wr_word <= w;
    if (wr && push) begin
      m = mem.exists(a) ? mem[a] : '0;
      for (int i = 0; i < 4; i++) begin
        if (!ln[i]) begin
          m[9*i+:9] = w[9*i+:9];
        end
      end
      mem[a] = m;
    end else if (push) begin
      exp_q.push_back(mem[a]);
    end
  endtask

  task automatic hold(input int n);
    logic [`PSS_DATA_W-1:0] w;
    repeat (n) begin
      w = rword();
      @(posedge core_clk);
      clock_hold_n <= 1'b1;
      advance_or_load <= w[18];
      address <= w[`PSS_ADDR_W-1:0];
      read_write_n <= w[19];
      wr_beat <= 1'b1;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) beat(1'b0, 1'b0, '0, '0, 1'b0, 0);
  endtask

  task automatic burst(input logic wr, input logic [`PSS_ADDR_W-1:0] a, input logic [3:0] ln,
                       input logic push, input int h);
    logic [1:0] lo;
    for (int n = 0; n < 4; n++) begin
      lo = burst_interleave ? a[1:0] ^ n[1:0] : a[1:0] + n[1:0];
      beat(n != 0, wr, {a[`PSS_ADDR_W-1:2], lo}, ln, push, 3);
      if (n == 0) hold(h);
    end
  endtask

  // ***********************************
  // result watcher
  // ***********************************
  always @(posedge core_clk) counted <= clock_hold_n === 1'b0;

  always @(negedge core_clk) begin
    if (counted && data_byte_lanes_oe === 4'hf) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("CHECK FAILED at %0t: expected %h got %h", $time, {`PSS_DATA_W{1'bx}},
                 data_byte_lanes_out);
      end else begin
        check(exp_q.pop_front(), data_byte_lanes_out);
      end
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end

  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    logic [`PSS_ADDR_W-1:0] a;
    logic [`PSS_DATA_W-1:0] w;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      idle(1);
      burst_interleave <= m[0];
      idle(3);
      for (int s = 0; s < 4; s++) begin
        w = rword();
        a = {w[19:4], s[1:0]};
        burst(1'b1, a, 4'h0, 1'b1, 0);
        burst(1'b0, a, 4'h0, 1'b1, 0);
        burst(1'b1, a, w[31:28], 1'b1, s);
        burst(1'b0, a, 4'h0, 1'b1, 3 - s);
      end
    end
    for (int i = 0; i < 3; i++) begin
      beat(1'b0, 1'b0, a, '0, 1'b1, 3);
      beat(1'b1, 1'b0, a ^ 18'h1, '0, 1'b1, 3);
      beat(1'b0, 1'b0, a, '0, 1'b0, i);
      beat(1'b1, 1'b0, a, '0, 1'b0, 3);
      idle(3);
    end
    @(negedge core_clk);
    check(`PSS_DATA_W'(1), `PSS_DATA_W'(power_down));
    @(posedge core_clk) out_enable_n <= 1'b1;
    burst(1'b0, a, 4'h0, 1'b0, 0);
    idle(3);
    @(posedge core_clk) out_enable_n <= 1'b0;
    @(posedge core_clk) sleep_request <= 1'b1;
    idle(3);
    @(negedge core_clk);
    check(`PSS_DATA_W'(1), `PSS_DATA_W'(power_down));
    burst(1'b0, a, 4'h0, 1'b0, 0);
    @(posedge core_clk) sleep_request <= 1'b0;
    idle(4);
    check('0, `PSS_DATA_W'(exp_q.size()));
    end_sim();
  end
endmodule
